// ==== rtl/pjs_sequencer.sv ====
// Purpose: automatic test motion program sequencer for a linear axis
// Assumes: APB slave, 10 MHz clock, move_done pulses once per finished move
// Notes:   keys arrive as writes to the control register
`include "pjs_cfg.svh"
module pjs_sequencer import pjs_pkg::*; #(
   parameter int CYC_PER_MS = `PJS_CYC_PER_MS
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_b,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // position control path
   output logic             servo_power,
   output logic             move_req,
   output logic             move_dir_up,
   output logic [30:0]      move_distance,
   output logic [13:0]      move_speed,
   output logic [13:0]      ramp_time,
   input  wire logic        move_done,
   // status
   output logic             end_indication,
   output logic             seq_active
);

   pjs_top_t s;
   pjs_top_t next_s;

   logic       wait_done;
   logic       end_done;
   logic       forward;
   logic       dir_up;
   logic       two_leg;
   logic       two_half;
   logic       first_forward;
   logic       first_dir_up;
   logic       first_two_leg;
   logic       first_two_half;
   logic       acc;
   logic       wr;
   logic       mapped;
   logic       range_ok;
   logic       key_fwd;
   logic       key_rev;
   logic       key_pwr;
   logic       endless;
   logic [9:0] reps_next;
   logic [31:0] rd_val;

   // wait interval timer
   pjs_ms_timer #(
      .CYC_PER_MS (CYC_PER_MS)
   ) u_wait_timer (
      .clock   (clock),
      .rst_b   (rst_b),
      .start   (s.wait_start),
      .load_ms (s.wait_ms),
      .done    (wait_done),
      .busy    ()
   );

   // end indication timer
   pjs_ms_timer #(
      .CYC_PER_MS (CYC_PER_MS)
   ) u_end_timer (
      .clock   (clock),
      .rst_b   (rst_b),
      .start   (s.end_start),
      .load_ms (`PJS_END_SHOW_MS),
      .done    (end_done),
      .busy    ()
   );

   // step being run now
   pjs_step_planner u_plan_now (
      .pattern     (s.pattern),
      .second_half (s.second_half),
      .leg         (s.leg),
      .dir_sel     (s.dir_sel),
      .forward     (forward),
      .dir_up      (dir_up),
      .two_leg     (two_leg),
      .two_half    (two_half)
   );

   // first step of the pattern, for the start key
   pjs_step_planner u_plan_first (
      .pattern     (s.pattern),
      .second_half (1'b0),
      .leg         (1'b0),
      .dir_sel     (s.dir_sel),
      .forward     (first_forward),
      .dir_up      (first_dir_up),
      .two_leg     (first_two_leg),
      .two_half    (first_two_half)
   );

   // bus decode and range check
   always_comb begin
      acc      = psel && penable;
      wr       = acc && pwrite;
      mapped   = (paddr[1:0] == 2'h0) && (paddr <= `PJS_OFF_STATUS);
      range_ok = 1'b1;
      if (pwrite) begin
         case (paddr)
            `PJS_OFF_PATTERN:  range_ok = pwdata <= 32'(`PJS_MAX_PATTERN);
            `PJS_OFF_DISTANCE: range_ok = (pwdata >= 32'(`PJS_MIN_DISTANCE))
                                       && (pwdata <= 32'(`PJS_MAX_DISTANCE));
            `PJS_OFF_SPEED:    range_ok = (pwdata >= 32'(`PJS_MIN_SPEED))
                                       && (pwdata <= 32'(`PJS_MAX_SPEED));
            `PJS_OFF_RAMP:     range_ok = (pwdata >= 32'(`PJS_MIN_RAMP))
                                       && (pwdata <= 32'(`PJS_MAX_RAMP));
            `PJS_OFF_WAIT:     range_ok = pwdata <= 32'(`PJS_MAX_WAIT);
            `PJS_OFF_REPEAT:   range_ok = pwdata <= 32'(`PJS_MAX_REPEAT);
            `PJS_OFF_STATUS:   range_ok = 1'b0;
            default:           range_ok = 1'b1;
         endcase
      end
      key_fwd = wr && mapped && (paddr == `PJS_OFF_CONTROL) && pwdata[`PJS_CTL_KEY_FWD];
      key_rev = wr && mapped && (paddr == `PJS_OFF_CONTROL) && pwdata[`PJS_CTL_KEY_REV];
      key_pwr = wr && mapped && (paddr == `PJS_OFF_CONTROL) && pwdata[`PJS_CTL_KEY_PWR];
   end

   // read mux, sampled in the setup cycle
   always_comb begin
      case (paddr)
         `PJS_OFF_PATTERN:  rd_val = {29'h0, s.pattern};
         `PJS_OFF_DISTANCE: rd_val = {1'h0, s.distance};
         `PJS_OFF_SPEED:    rd_val = {18'h0, s.speed};
         `PJS_OFF_RAMP:     rd_val = {18'h0, s.ramp};
         `PJS_OFF_WAIT:     rd_val = {18'h0, s.wait_ms};
         `PJS_OFF_REPEAT:   rd_val = {22'h0, s.repeat_cnt};
         `PJS_OFF_CONTROL:  rd_val = {31'h0, s.dir_sel};
         `PJS_OFF_STATUS:   rd_val = {6'h0, s.reps_done, 9'h0, s.leg, s.second_half,
                                      endless, s.end_ind, s.power, s.state};
         default:           rd_val = 32'h0;
      endcase
   end

   assign endless   = (s.repeat_cnt == 10'h0) && !two_half;
   assign reps_next = s.reps_done + 10'h1;

   always_comb begin
      next_s            = s;
      next_s.wait_start = 1'b0;
      next_s.end_start  = 1'b0;
      if (psel && !penable) begin
         next_s.prdata = rd_val;
      end

      // register writes, live at once
      if (wr && mapped && range_ok) begin
         case (paddr)
            `PJS_OFF_PATTERN:  next_s.pattern    = pwdata[2:0];
            `PJS_OFF_DISTANCE: next_s.distance   = pwdata[30:0];
            `PJS_OFF_SPEED:    next_s.speed      = pwdata[13:0];
            `PJS_OFF_RAMP:     next_s.ramp       = pwdata[13:0];
            `PJS_OFF_WAIT:     next_s.wait_ms    = pwdata[13:0];
            `PJS_OFF_REPEAT:   next_s.repeat_cnt = pwdata[9:0];
            `PJS_OFF_CONTROL:  next_s.dir_sel    = pwdata[`PJS_CTL_DIRSEL];
            default:           next_s.dir_sel    = s.dir_sel;
         endcase
      end

      case (s.state)
         PJS_IDLE: begin
            if (s.power && ((key_fwd && first_forward) || (key_rev && !first_forward))) begin
               next_s.second_half = 1'b0;
               next_s.leg         = 1'b0;
               next_s.reps_done   = 10'h0;
               if (first_two_half && s.repeat_cnt == 10'h0) begin
                  next_s.state     = PJS_END;
                  next_s.end_ind   = 1'b1;
                  next_s.end_start = 1'b1;
               end else begin
                  next_s.state      = PJS_WAIT;
                  next_s.wait_start = 1'b1;
               end
            end
         end
         PJS_WAIT: begin
            if (wait_done) begin
               next_s.state       = PJS_MOVE;
               next_s.move_req    = 1'b1;
               next_s.move_dir_up = dir_up;
            end
         end
         PJS_MOVE: begin
            if (move_done) begin
               next_s.move_req   = 1'b0;
               next_s.state      = PJS_WAIT;
               next_s.wait_start = 1'b1;
               if (two_leg && !s.leg) begin
                  next_s.leg = 1'b1;
               end else begin
                  next_s.leg = 1'b0;
                  if (endless) begin
                     next_s.reps_done = reps_next;
                  end else if (reps_next >= s.repeat_cnt) begin
                     if (two_half && !s.second_half) begin
                        next_s.second_half = 1'b1;
                        next_s.reps_done   = 10'h0;
                     end else begin
                        next_s.state      = PJS_END;
                        next_s.wait_start = 1'b0;
                        next_s.end_ind    = 1'b1;
                        next_s.end_start  = 1'b1;
                     end
                  end else begin
                     next_s.reps_done = reps_next;
                  end
               end
            end
         end
         PJS_END: begin
            if (end_done) begin
               next_s.state       = PJS_IDLE;
               next_s.end_ind     = 1'b0;
               next_s.second_half = 1'b0;
               next_s.leg         = 1'b0;
            end
         end
         default: begin
            next_s.state = PJS_IDLE;
         end
      endcase

      // power toggle key wins over everything
      if (key_pwr) begin
         if (s.power) begin
            next_s.power       = 1'b0;
            next_s.state       = PJS_IDLE;
            next_s.move_req    = 1'b0;
            next_s.end_ind     = 1'b0;
            next_s.wait_start  = 1'b0;
            next_s.end_start   = 1'b0;
            next_s.second_half = 1'b0;
            next_s.leg         = 1'b0;
         end else if (s.state == PJS_IDLE) begin
            next_s.power = 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         s            <= '0;
         s.state      <= PJS_IDLE;
         s.pattern    <= `PJS_RST_PATTERN;
         s.distance   <= `PJS_RST_DISTANCE;
         s.speed      <= `PJS_RST_SPEED;
         s.ramp       <= `PJS_RST_RAMP;
         s.wait_ms    <= `PJS_RST_WAIT;
         s.repeat_cnt <= `PJS_RST_REPEAT;
      end else begin
         s <= next_s;
      end
   end

   // apb answer in the access phase, no wait states
   assign pready  = psel && penable;
   assign pslverr = acc && (!mapped || !range_ok);
   assign prdata  = s.prdata;

   assign servo_power    = s.power;
   assign move_req       = s.move_req;
   assign move_dir_up    = s.move_dir_up;
   assign move_distance  = s.distance;
   assign move_speed     = s.speed;
   assign ramp_time      = s.ramp;
   assign end_indication = s.end_ind;
   assign seq_active     = (s.state == PJS_WAIT) || (s.state == PJS_MOVE);

endmodule

// ==== rtl/pjs_cfg.svh ====
// Purpose: constants of the program jog sequencer
// Assumes: 10 MHz clock, byte addresses on APB
// Notes:   times are held in their own unit, cycle counts derived
`ifndef PJS_CFG_SVH
`define PJS_CFG_SVH

// register byte offsets
`define PJS_OFF_PATTERN   8'h00
`define PJS_OFF_DISTANCE  8'h04
`define PJS_OFF_SPEED     8'h08
`define PJS_OFF_RAMP      8'h0c
`define PJS_OFF_WAIT      8'h10
`define PJS_OFF_REPEAT    8'h14
`define PJS_OFF_CONTROL   8'h18
`define PJS_OFF_STATUS    8'h1c

// control register bit positions
`define PJS_CTL_DIRSEL    0
`define PJS_CTL_KEY_FWD   1
`define PJS_CTL_KEY_REV   2
`define PJS_CTL_KEY_PWR   3

// reset values
`define PJS_RST_PATTERN   3'h0
`define PJS_RST_DISTANCE  31'h0000_8000
`define PJS_RST_SPEED     14'h01f4
`define PJS_RST_RAMP      14'h0064
`define PJS_RST_WAIT      14'h0064
`define PJS_RST_REPEAT    10'h001

// accepted ranges
`define PJS_MAX_PATTERN   3'h5
`define PJS_MIN_DISTANCE  31'h0000_0001
`define PJS_MAX_DISTANCE  31'h4000_0000
`define PJS_MIN_SPEED     14'h0001
`define PJS_MAX_SPEED     14'h2710
`define PJS_MIN_RAMP      14'h0002
`define PJS_MAX_RAMP      14'h2710
`define PJS_MAX_WAIT      14'h2710
`define PJS_MAX_REPEAT    10'h3e8

// timing
`define PJS_CLK_PERIOD_NS 100
`define PJS_MS_NS         1000000
`define PJS_CYC_PER_MS    ((`PJS_MS_NS + `PJS_CLK_PERIOD_NS - 1) / `PJS_CLK_PERIOD_NS)
`define PJS_END_SHOW_MS   14'h03e8

`endif

// ==== rtl/pjs_pkg.sv ====
// Purpose: types of the program jog sequencer
// Assumes: nothing
// Notes:   state codes are gray along idle, wait, move, end
package pjs_pkg;

   typedef enum logic [1:0] {
      PJS_IDLE = 2'h0,
      PJS_WAIT = 2'h1,
      PJS_MOVE = 2'h3,
      PJS_END  = 2'h2
   } pjs_state_t;

   typedef struct packed {
      logic        busy;
      logic        done;
      logic [13:0] remaining;
      logic [31:0] prescale;
   } pjs_timer_t;

   typedef struct packed {
      pjs_state_t  state;
      logic [2:0]  pattern;
      logic [30:0] distance;
      logic [13:0] speed;
      logic [13:0] ramp;
      logic [13:0] wait_ms;
      logic [9:0]  repeat_cnt;
      logic        dir_sel;
      logic        power;
      logic        end_ind;
      logic        second_half;
      logic        leg;
      logic [9:0]  reps_done;
      logic        move_req;
      logic        move_dir_up;
      logic        wait_start;
      logic        end_start;
      logic [31:0] prdata;
   } pjs_top_t;

endpackage

// ==== rtl/pjs_ms_timer.sv ====
// Purpose: millisecond down timer with its own prescaler
// Assumes: start is a one-cycle pulse
// Notes:   a start while busy restarts the count
`include "pjs_cfg.svh"
module pjs_ms_timer import pjs_pkg::*; #(
   parameter int CYC_PER_MS = `PJS_CYC_PER_MS
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_b,
   // control
   input  wire logic        start,
   input  wire logic [13:0] load_ms,
   // result
   output logic             done,
   output logic             busy
);

   pjs_timer_t s;
   pjs_timer_t next_s;

   always_comb begin
      next_s      = s;
      next_s.done = 1'b0;
      if (start) begin
         next_s.busy      = 1'b1;
         next_s.remaining = load_ms;
         next_s.prescale  = 32'h0;
      end else if (s.busy) begin
         if (s.remaining == 14'h0) begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
         end else if (s.prescale == 32'(CYC_PER_MS - 1)) begin
            next_s.prescale  = 32'h0;
            next_s.remaining = s.remaining - 14'h1;
         end else begin
            next_s.prescale = s.prescale + 32'h1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign done = s.done;
   assign busy = s.busy;

endmodule

// ==== rtl/pjs_step_planner.sv ====
// Purpose: direction and shape of the current step of a pattern
// Assumes: pattern already limited to 0..5
// Notes:   purely combinational
module pjs_step_planner import pjs_pkg::*; (
   // position within the pattern
   input  wire logic [2:0] pattern,
   input  wire logic       second_half,
   input  wire logic       leg,
   input  wire logic       dir_sel,
   // plan
   output logic            forward,
   output logic            dir_up,
   output logic            two_leg,
   output logic            two_half
);

   always_comb begin
      case (pattern)
         3'h0:    forward = 1'b1;
         3'h1:    forward = 1'b0;
         3'h2:    forward = !second_half;
         3'h3:    forward = second_half;
         3'h4:    forward = !leg;
         3'h5:    forward = leg;
         default: forward = 1'b1;
      endcase
      two_leg  = (pattern == 3'h4) || (pattern == 3'h5);
      two_half = (pattern == 3'h2) || (pattern == 3'h3);
      dir_up   = forward ^ dir_sel;
   end

endmodule

// ==== verification/pjs_seq_monitor.sv ====
// Purpose: port checker of the program jog sequencer
// Assumes: one clock, bound to pjs_sequencer
// Notes:   end window length counted in helper logic
`include "pjs_cfg.svh"
module pjs_seq_monitor import pjs_pkg::*; #(
   parameter int CYC_PER_MS = 4
) (
   // clock and reset
   input wire logic        clock,
   input wire logic        rst_b,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // motion
   input wire logic        servo_power,
   input wire logic        move_req,
   input wire logic        move_dir_up,
   input wire logic [30:0] move_distance,
   input wire logic [13:0] move_speed,
   input wire logic [13:0] ramp_time,
   input wire logic        move_done,
   input wire logic        end_indication,
   input wire logic        seq_active
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int END_CYC = 1000 * CYC_PER_MS;
   logic [31:0] wdat;
   logic [31:0] end_cnt;
   logic        wr_ok;
   assign wr_ok = psel && penable && pwrite && !pslverr;
   always_ff @(posedge clock) begin
      wdat <= pwdata;
      if (!rst_b || !end_indication) begin
         end_cnt <= 32'h0;
      end else begin
         end_cnt <= end_cnt + 32'h1;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   property p_ready; psel && penable |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("pready missing");
   property p_dist; wr_ok && paddr == `PJS_OFF_DISTANCE |=> move_distance == wdat[30:0];
   endproperty
   a_dist: assert property (p_dist) else $error("distance not live");
   property p_ramp; wr_ok && paddr == `PJS_OFF_RAMP |=> ramp_time == wdat[13:0]; endproperty
   a_ramp: assert property (p_ramp) else $error("ramp not live");
   property p_speed; wr_ok && paddr == `PJS_OFF_SPEED |=> move_speed == wdat[13:0]; endproperty
   a_speed: assert property (p_speed) else $error("speed not live");
   property p_hold; move_req && !move_done |=> move_req || !servo_power; endproperty
   a_hold: assert property (p_hold) else $error("move dropped early");
   property p_drop; move_req && move_done |=> !move_req; endproperty
   a_drop: assert property (p_drop) else $error("move not ended");
   property p_dir; move_req ##1 move_req |-> $stable(move_dir_up); endproperty
   a_dir: assert property (p_dir) else $error("direction changed in move");
   property p_pwr; !servo_power |=> !move_req && !seq_active; endproperty
   a_pwr: assert property (p_pwr) else $error("motion without power");
   property p_end; end_indication |-> !move_req && !seq_active; endproperty
   a_end: assert property (p_end) else $error("motion during end");
   property p_end_len;
      $fell(end_indication) && servo_power |-> end_cnt >= END_CYC && end_cnt <= END_CYC + 4;
   endproperty
   a_end_len: assert property (p_end_len) else $error("end length wrong");
   c_end: cover property ($rose(end_indication));
   c_off: cover property ($fell(servo_power));
   c_move: cover property (move_req && move_done);
endmodule

bind pjs_sequencer pjs_seq_monitor #(.CYC_PER_MS(CYC_PER_MS)) pjs_seq_monitor_inst (
   .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .servo_power(servo_power), .move_req(move_req), .move_dir_up(move_dir_up),
   .move_distance(move_distance), .move_speed(move_speed), .ramp_time(ramp_time),
   .move_done(move_done), .end_indication(end_indication), .seq_active(seq_active));

// ==== verification/pjs_motion_model.sv ====
// Purpose: position control path answering move commands
// Assumes: one move_done pulse per commanded move
// Notes:   slow stretches each move
module pjs_motion_model (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // command
   input wire logic servo_power,
   input wire logic move_req,
   input wire logic slow,
   // answer
   output logic     move_done
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt;
   always_ff @(posedge clock) begin
      move_done <= 1'b0;
      if (!rst_b || !servo_power || !move_req) begin
         cnt <= 0; // power removed abandons the move
      end else if (cnt == (slow ? 12 : 1)) begin
         move_done <= 1'b1;
         cnt       <= -1;
      end else if (cnt >= 0) begin
         cnt <= cnt + 1;
      end
   end
endmodule

// ==== verification/pjs_sequencer_tb_top.sv ====
// Purpose: self-checking bench of the program jog sequencer
// Assumes: CYC_PER_MS of 4, keys by control writes
// Notes:   direction queue model checked at every move
module pjs_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock;
   logic        rst_b;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        servo_power;
   logic        move_req;
   logic        move_dir_up;
   logic [30:0] move_distance;
   logic [13:0] move_speed;
   logic [13:0] ramp_time;
   logic        move_done;
   logic        end_indication;
   logic        seq_active;
   logic        slow;
   logic        mr_d = 1'b0;
   int          err_total = 0;
   int          checks_done = 0;
   int          moves = 0;
   int          exp_moves = 0;
   int          seed;
   logic [31:0] rd;
   logic [31:0] v;
   logic [31:0] s;
   logic [31:0] r;
   logic        er;
   bit          dq[$];
   logic [7:0]  offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
   logic [31:0] dflt [6] = '{32'h0, 32'h8000, 32'h1f4, 32'h64, 32'h64, 32'h1};
   logic [31:0] lo [6] = '{32'h0, 32'h1, 32'h1, 32'h2, 32'h0, 32'h0};
   logic [31:0] hi [6] = '{32'h5, 32'h4000_0000, 32'h2710, 32'h2710, 32'h2710, 32'h3e8};

   pjs_sequencer #(.CYC_PER_MS(4)) pjs_sequencer_inst (
      .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .servo_power(servo_power), .move_req(move_req), .move_dir_up(move_dir_up),
      .move_distance(move_distance), .move_speed(move_speed), .ramp_time(ramp_time),
      .move_done(move_done), .end_indication(end_indication), .seq_active(seq_active));
   pjs_motion_model pjs_motion_model_inst (.clock(clock), .rst_b(rst_b),
      .servo_power(servo_power), .move_req(move_req), .slow(slow), .move_done(move_done));

   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s exp %0h got %0h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clock);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic sig(input int k);
      case (k)
         0: return move_req;
         1: return !move_req;
         2: return end_indication;
         default: return !end_indication;
      endcase
   endfunction
   task automatic wait_for(input int k, output int n);
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (sig(k) !== 1'b1 && n < 50000);
      if (n >= 50000) cmp("wait", 1, 0);
   endtask
   task automatic plan(input int p, input int c, input bit ds, input bit f);
      dq.delete();
      for (int i = 0; i < c; i++) begin
         dq.push_back(f ^ ds);
         if (p > 3) dq.push_back(!f ^ ds);
      end
      if (p == 2 || p == 3) for (int i = 0; i < c; i++) dq.push_back(!f ^ ds);
      exp_moves += dq.size();
   endtask
   task automatic run(input int p, input int c, input bit ds, input int w);
      int n;
      bit f;
      bit inf;
      f   = (p % 2 == 0);
      inf = (c == 0) && (p < 2 || p > 3);
      plan(p, inf ? 3 : c, ds, f);
      apb(1'b1, 8'h00, p);
      apb(1'b1, 8'h14, c);
      apb(1'b1, 8'h10, w);
      apb(1'b1, 8'h18, 32'h8 | ds);
      apb(1'b1, 8'h18, (f ? 32'h4 : 32'h2) | ds);
      @(posedge clock);
      @(posedge clock);
      cmp("power on", 1, servo_power);
      cmp("wrong key", 0, seq_active);
      apb(1'b1, 8'h18, (f ? 32'h2 : 32'h4) | ds);
      for (int i = 0; dq.size() > 0; i++) begin
         wait_for(0, n);
         if (i == 0) cmp("delay", 1, n > 4 * w && n < 4 * w + 8);
         cmp("dir", dq.pop_front(), move_dir_up);
         wait_for(1, n);
      end
      if (inf) begin
         apb(1'b1, 8'h18, 32'h8 | ds);
         @(posedge clock);
         @(posedge clock);
         cmp("stopped", 0, {servo_power, move_req, seq_active});
      end else begin
         wait_for(2, n);
         wait_for(3, n);
         cmp("end length", 1, n >= 4000 && n <= 4006);
         cmp("running", 1, servo_power);
         apb(1'b1, 8'h18, 32'h8 | ds);
      end
      cmp("moves", exp_moves, moves);
   endtask

   always @(posedge clock) begin
      if (move_req === 1'b1 && mr_d !== 1'b1) moves++;
      mr_d <= move_req;
   end
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   initial begin
      repeat (90000) @(posedge clock);
      err_total++;
      finish_test();
   end
   initial begin
      {rst_b, psel, penable, pwrite, slow} = 5'h0;
      paddr  = 8'h0;
      pwdata = 32'h0;
      seed   = 33;
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, offs[i], 32'h0);
         cmp("default", dflt[i], rd);
      end
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, offs[i], hi[i] + 1);
         cmp("high refused", 1, er);
         apb(1'b1, offs[i], hi[i]);
         cmp("high taken", 0, er);
         if (lo[i] > 0) begin
            apb(1'b1, offs[i], lo[i] - 1);
            cmp("low refused", 1, er);
         end
         apb(1'b0, offs[i], 32'h0);
         cmp("kept", hi[i], rd);
         apb(1'b1, offs[i], lo[i]);
      end
      apb(1'b0, 8'h20, 32'h0);
      cmp("unmapped", 32'h0, rd);
      cmp("unmapped err", 32'h1, {31'h0, er});
      apb(1'b1, 8'h1c, 32'h0);
      cmp("status write", 1, er);
      repeat (4) begin
         v = {$random(seed)} % 32'h4000_0000 + 1;
         s = {$random(seed)} % 10000 + 1;
         r = {$random(seed)} % 9999 + 2;
         apb(1'b1, 8'h04, v);
         apb(1'b1, 8'h08, s);
         apb(1'b1, 8'h0c, r);
         @(posedge clock);
         cmp("distance", v, {1'b0, move_distance});
         cmp("speed", s, {18'h0, move_speed});
         cmp("ramp", r, {18'h0, ramp_time});
      end
      apb(1'b1, 8'h04, 32'h100);
      for (int p = 0; p < 6; p++) begin
         slow <= p[0];
         run(p, 2, p[1], p % 2);
      end
      run(0, 1, 1'b1, 0);
      run(4, 0, 1'b0, 2);
      run(1, 0, 1'b1, 2);
      run(2, 0, 1'b0, 1);
      run(3, 0, 1'b1, 1);
      finish_test();
   end
endmodule
